// File: shared/keyer_pkg.sv
// Purpose: constants and types shared by the beacon keyer
// Assumes: mclk at 250 MHz
// Notes:   one bit period is 125 ms, so a 64-bit frame lasts 8 s
package keyer_pkg;
   localparam int unsigned CLK_HZ         = 250_000_000;
   localparam int unsigned BIT_MS         = 125;
   localparam int unsigned BIT_CYCLES     = CLK_HZ / 1000 * BIT_MS;
   localparam int unsigned FRAME_BITS     = 64;
   localparam int unsigned FRAME_SLOTS    = 8;
   localparam int unsigned PROG_PAIRS     = 25;
   localparam int unsigned TONE_HI_HZ     = 1020;
   localparam int unsigned TONE_LO_HZ     = 400;
   localparam int unsigned TONE_HI_HALF   = CLK_HZ / (2 * TONE_HI_HZ);
   localparam int unsigned TONE_LO_HALF   = CLK_HZ / (2 * TONE_LO_HZ);
   localparam logic [1:0]  RST_SLOT       = 2'h0;

   // Selection of one bit pair, as wired by the installer
   typedef enum logic [1:0] {
      pair_dash,
      pair_open,
      pair_gap,
      pair_stretch
   } pair_sel_e;

   // Content of one frame slot
   typedef enum logic [1:0] {
      frame_ident,
      tone_frame,
      silent_frame
   } frame_sel_e;
endpackage

// File: hdl/beacon_morse_keyer.sv
// Purpose: Morse keyer for a radiobeacon, driving the keyed tone out
// Assumes: straps and selector inputs are static and synchronous to mclk
// Notes:   a pair input is a 2-bit code per pair_sel_e, frame inputs per frame_sel_e
`timescale 1ns/10ps
module beacon_morse_keyer
   import keyer_pkg::*;
#(
   parameter int unsigned BIT_LEN     = BIT_CYCLES,
   parameter int unsigned TONE_HI_LEN = TONE_HI_HALF,
   parameter int unsigned TONE_LO_LEN = TONE_LO_HALF
) (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic [2*PROG_PAIRS-1:0] pair_sel,
   input  wire logic [2*FRAME_SLOTS-1:0] frame_sel,
   input  wire logic                  standby_one,
   input  wire logic                  tone_strap_b,
   input  wire logic                  tone_strap_c,
   input  wire logic                  source_strap,
   input  wire logic                  ext_tone,
   output logic                       keyed_tone,
   output logic                       key_on
);

   typedef enum logic [1:0] {
      st_frame,
      st_stretch
   } run_e;

   typedef struct packed {
      run_e        run;
      logic [31:0] bit_cnt;
      logic [5:0]  bit_pos;
      logic [2:0]  slot;
      logic [5:0]  stretch_left;
      logic [31:0] osc_cnt;
      logic        osc;
      logic        key;
      logic        out;
   } state_s;

   state_s cur_reg;
   state_s cur_next;

   // Tone value of one pattern bit: bit 0 fixed, bits 1..50 from pair codes
   function automatic logic pattern_bit(input logic [5:0] pos,
                                        input logic [2*PROG_PAIRS-1:0] sel);
      logic [5:0] idx;
      logic [1:0] code;
      idx  = 6'h00;
      code = 2'h0;
      if (pos == 6'h00) begin
         return 1'b1;
      end
      if (pos > 6'(2*PROG_PAIRS)) begin
         return 1'b0;
      end
      idx  = 6'((pos - 6'h01) >> 1);
      code = sel[2*idx +: 2];
      case (pair_sel_e'(code))
         pair_dash: return 1'b1;
         pair_open: return pos[0] == 1'b0;
         default:   return 1'b0;
      endcase
   endfunction

   function automatic logic pair_stretches(input logic [5:0] pos,
                                           input logic [2*PROG_PAIRS-1:0] sel);
      logic [5:0] idx;
      idx = 6'h00;
      if (pos == 6'h00 || pos > 6'(2*PROG_PAIRS)) begin
         return 1'b0;
      end
      idx = 6'((pos - 6'h01) >> 1);
      return pair_sel_e'(sel[2*idx +: 2]) == pair_stretch;
   endfunction

   logic       hi_tone;
   logic [1:0] slot_code;
   logic       mark;
   logic       bit_end;
   logic       tone_src;

   always_comb begin
      hi_tone   = tone_strap_b & tone_strap_c;
      slot_code = frame_sel[2*cur_reg.slot +: 2];
      bit_end   = cur_reg.bit_cnt == BIT_LEN - 1;
      case (frame_sel_e'(slot_code))
         tone_frame:   mark = 1'b1;
         silent_frame: mark = 1'b0;
         default:      mark = pattern_bit(cur_reg.bit_pos, pair_sel);
      endcase
      if (cur_reg.run == st_stretch) begin
         mark = 1'b0;
      end
      tone_src = source_strap ? cur_reg.osc : ext_tone;

      cur_next = cur_reg;
      cur_next.bit_cnt = bit_end ? 32'h0 : cur_reg.bit_cnt + 32'h1;
      // Internal tone oscillator
      if (cur_reg.osc_cnt >= (hi_tone ? TONE_HI_LEN : TONE_LO_LEN) - 1) begin
         cur_next.osc_cnt = 32'h0;
         cur_next.osc     = ~cur_reg.osc;
      end else begin
         cur_next.osc_cnt = cur_reg.osc_cnt + 32'h1;
      end
      case (cur_reg.run)
         st_frame: begin
            if (bit_end) begin
               cur_next.key = mark;
               if (standby_one && frame_sel_e'(slot_code) == frame_ident
                   && pair_stretches(cur_reg.bit_pos, pair_sel)) begin
                  cur_next.run          = st_stretch;
                  cur_next.stretch_left = 6'h02;
                  cur_next.key          = 1'b0;
               end else if (cur_reg.bit_pos == 6'(FRAME_BITS - 1)) begin
                  cur_next.bit_pos = 6'h00;
                  cur_next.slot    = cur_reg.slot + 3'h1;
               end else begin
                  cur_next.bit_pos = cur_reg.bit_pos + 6'h01;
               end
            end
         end
         st_stretch: begin
            if (bit_end) begin
               cur_next.key = 1'b0;
               if (cur_reg.stretch_left == 6'h01) begin
                  cur_next.run     = st_frame;
                  cur_next.bit_pos = cur_reg.bit_pos + 6'h01;
               end
               cur_next.stretch_left = cur_reg.stretch_left - 6'h01;
            end
         end
         default: cur_next.run = st_frame;
      endcase
      cur_next.out = cur_next.key & tone_src;
      if (rst) begin
         cur_next = '0;
      end
   end

   always_ff @(posedge mclk) begin
      cur_reg <= cur_next;
   end

   assign keyed_tone = cur_reg.out;
   assign key_on     = cur_reg.key;

   // Assertions
   // Code of the pair covering pattern bit pos, valid for bits 1..50
   function automatic logic [1:0] pair_code(input logic [5:0] pos,
                                            input logic [2*PROG_PAIRS-1:0] sel);
      logic [5:0] idx;
      idx = 6'((pos - 6'h01) >> 1);
      return sel[2*idx +: 2];
   endfunction

   logic in_prog;
   logic ident_bit;

   always_comb begin
      in_prog   = cur_reg.bit_pos != 6'h00 && cur_reg.bit_pos <= 6'(2*PROG_PAIRS);
      ident_bit = bit_end && cur_reg.run == st_frame
                  && frame_sel_e'(slot_code) != tone_frame
                  && frame_sel_e'(slot_code) != silent_frame;
   end

   sequence bit_boundary_s;
      $past(cur_reg.bit_cnt) == BIT_LEN - 1;
   endsequence

   sequence stretch_entry_s;
      cur_reg.run == st_frame ##1 cur_reg.run == st_stretch;
   endsequence

   sequence stretch_exit_s;
      cur_reg.run == st_stretch ##1 cur_reg.run == st_frame;
   endsequence

   // Envelope timing
   key_at_edge_a: assert property (@(posedge mclk) disable iff (rst)
      $changed(key_on) |-> cur_reg.bit_cnt == 32'h0)
      else $error("key changed off a bit edge");

   bit_count_a: assert property (@(posedge mclk) disable iff (rst)
      cur_reg.bit_cnt < BIT_LEN)
      else $error("bit counter out of range");

   pos_step_a: assert property (@(posedge mclk) disable iff (rst)
      $changed(cur_reg.bit_pos) |-> bit_boundary_s)
      else $error("bit position moved off a bit edge");

   frame_wrap_a: assert property (@(posedge mclk) disable iff (rst)
      bit_end && cur_reg.run == st_frame && cur_reg.bit_pos == 6'(FRAME_BITS - 1)
      |=> cur_reg.bit_pos == 6'h00)
      else $error("frame did not wrap at 64 bits");

   // Frame sequencer
   slot_step_a: assert property (@(posedge mclk) disable iff (rst)
      $changed(cur_reg.slot) |-> cur_reg.slot == $past(cur_reg.slot) + 3'h1)
      else $error("sequencer skipped a slot");

   slot_at_wrap_a: assert property (@(posedge mclk) disable iff (rst)
      $changed(cur_reg.slot) |-> cur_reg.bit_pos == 6'h00 ##0 bit_boundary_s)
      else $error("slot moved inside a frame");

   reset_clear_a: assert property (@(posedge mclk)
      rst |=> !key_on && !keyed_tone && cur_reg.slot == 3'h0 && cur_reg.bit_pos == 6'h00)
      else $error("reset did not restart the sequence");

   mark_frame_a: assert property (@(posedge mclk) disable iff (rst)
      bit_end && frame_sel_e'(slot_code) == tone_frame && cur_reg.run == st_frame
      |=> key_on)
      else $error("mark frame not keyed");

   space_frame_a: assert property (@(posedge mclk) disable iff (rst)
      bit_end && frame_sel_e'(slot_code) == silent_frame |=> !key_on)
      else $error("space frame keyed");

   // Identification pattern
   lead_bit_a: assert property (@(posedge mclk) disable iff (rst)
      ident_bit && cur_reg.bit_pos == 6'h00 |=> key_on)
      else $error("leading bit missing");

   dash_pair_a: assert property (@(posedge mclk) disable iff (rst)
      ident_bit && in_prog && pair_sel_e'(pair_code(cur_reg.bit_pos, pair_sel)) == pair_dash
      |=> key_on)
      else $error("dash pair not keyed");

   open_first_a: assert property (@(posedge mclk) disable iff (rst)
      ident_bit && in_prog && cur_reg.bit_pos[0]
      && pair_sel_e'(pair_code(cur_reg.bit_pos, pair_sel)) == pair_open
      |=> !key_on)
      else $error("open pair keyed in first position");

   open_second_a: assert property (@(posedge mclk) disable iff (rst)
      ident_bit && in_prog && !cur_reg.bit_pos[0]
      && pair_sel_e'(pair_code(cur_reg.bit_pos, pair_sel)) == pair_open
      |=> key_on)
      else $error("open pair silent in second position");

   gap_pair_a: assert property (@(posedge mclk) disable iff (rst)
      ident_bit && in_prog && pair_code(cur_reg.bit_pos, pair_sel) inside {2'h2, 2'h3}
      |=> !key_on)
      else $error("gap pair keyed");

   idle_tail_a: assert property (@(posedge mclk) disable iff (rst)
      ident_bit && cur_reg.bit_pos > 6'(2*PROG_PAIRS) |=> !key_on)
      else $error("bit past the pattern keyed");

   // Stretched character gap
   stretch_quiet_a: assert property (@(posedge mclk) disable iff (rst)
      cur_reg.run == st_stretch && bit_end |=> !key_on)
      else $error("stretched gap keyed");

   stretch_entry_a: assert property (@(posedge mclk) disable iff (rst)
      stretch_entry_s |-> cur_reg.stretch_left == 6'h02 && !key_on && $past(standby_one))
      else $error("stretch entered wrongly");

   stretch_span_a: assert property (@(posedge mclk) disable iff (rst)
      cur_reg.run == st_stretch
      |-> cur_reg.stretch_left == 6'h01 || cur_reg.stretch_left == 6'h02)
      else $error("stretch count out of range");

   stretch_exit_a: assert property (@(posedge mclk) disable iff (rst)
      stretch_exit_s |-> $past(cur_reg.stretch_left) == 6'h01 ##0 bit_boundary_s)
      else $error("stretch left early");

   // Tone path
   tone_gate_a: assert property (@(posedge mclk) disable iff (rst)
      !key_on |-> !keyed_tone)
      else $error("tone leaked while keyed off");

   src_ext_a: assert property (@(posedge mclk) disable iff (rst)
      !source_strap |=> keyed_tone == (key_on && $past(ext_tone)))
      else $error("external tone not passed");

   src_int_a: assert property (@(posedge mclk) disable iff (rst)
      source_strap |=> keyed_tone == (key_on && $past(cur_reg.osc)))
      else $error("internal tone not passed");

   osc_edge_a: assert property (@(posedge mclk) disable iff (rst)
      $changed(cur_reg.osc) |-> cur_reg.osc_cnt == 32'h0)
      else $error("oscillator toggled off its count");
endmodule

// File: bench/tone_sink.sv
// Purpose: modulator model that takes the keyed tone and counts its pulses
// Assumes: keyed_tone is registered in the mclk domain
// Notes:   the carrier itself is not modelled, only the arrival of tone
`timescale 1ns/10ps
module tone_sink (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic keyed_tone,
   output int        pulses
);
   logic last;

   always_ff @(posedge mclk) begin
      last <= keyed_tone;
      if (rst) begin
         pulses <= 0;
      end else if (keyed_tone && !last) begin
         pulses <= pulses + 1;
      end
   end
endmodule

// File: bench/beacon_morse_keyer_test.sv
// Purpose: self-checking bench for the beacon keyer envelope and tone gating
// Assumes: short bit period; external tone source toggling every cycle
// Notes:   the envelope lags pattern content by one bit, so samples sit mid-period
`timescale 1ns/10ps
module beacon_morse_keyer_test;
   import keyer_pkg::*;
   localparam int unsigned BL = 8;
   localparam int unsigned TH = 5;
   localparam int unsigned TL = 7;
   localparam int unsigned CLK_NS = 4;
   logic        mclk;
   logic        rst;
   logic [49:0] pair_sel;
   logic [15:0] frame_sel;
   logic        standby_one;
   logic        tone_strap_b;
   logic        tone_strap_c;
   logic        source_strap;
   logic        ext_tone = 1'b0;
   logic        keyed_tone;
   logic        key_on;
   int          pulses;
   int          n_mismatch = 0;
   int          checks = 0;

   beacon_morse_keyer #(.BIT_LEN(BL), .TONE_HI_LEN(TH), .TONE_LO_LEN(TL)) dut_u (
      .mclk(mclk), .rst(rst), .pair_sel(pair_sel),
      .frame_sel(frame_sel), .standby_one(standby_one), .tone_strap_b(tone_strap_b),
      .tone_strap_c(tone_strap_c), .source_strap(source_strap), .ext_tone(ext_tone),
      .keyed_tone(keyed_tone), .key_on(key_on));
   tone_sink sink_u (.mclk(mclk), .rst(rst), .keyed_tone(keyed_tone), .pulses(pulses));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   always @(negedge mclk) ext_tone <= ~ext_tone;

   // Expected envelope of pattern bit b in a frame of the given code
   function automatic logic exp_key(input logic [1:0] fr, input int b);
      logic [1:0] pc;
      if (fr == tone_frame) return 1'b1;
      if (fr == silent_frame) return 1'b0;
      if (b == 0) return 1'b1;
      if (b > 50) return 1'b0;
      pc = pair_sel[2*((b-1)/2) +: 2];
      return (pc == pair_dash) || (pc == pair_open && b[0] == 1'b0);
   endfunction

   task automatic check(input string what, input logic seen, input logic want);
      checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0b seen %0b", what, want, seen);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #40000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      logic e;
      time  t0;
      rst = 1'b1;
      // Pairs cycle dash, open, gap, stretch; last pair is a dash
      pair_sel = {2'h0, {6{8'he4}}};
      // Slots: ident, tone, silent, code 3, ident, silent, tone, ident
      frame_sel = 16'h18e4;
      standby_one = 1'b0;
      tone_strap_b = 1'b1;
      tone_strap_c = 1'b1;
      source_strap = 1'b0;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      repeat (BL/2) @(negedge mclk);
      check("key_on first period", key_on, 1'b0);
      // Eight whole frames and the first bit of the wrapped frame
      for (int n = 0; n <= 8*64; n++) begin
         repeat (BL) @(negedge mclk);
         e = exp_key(frame_sel[2*((n/64)%8) +: 2], n % 64);
         check("key_on", key_on, e);
         if (!e) begin
            check("keyed_tone", keyed_tone, 1'b0);
         end
      end
      check("tone pulses seen", pulses > 0, 1'b1);
      // Reset in mid-run; all slots ident, stretched gaps on
      rst = 1'b1;
      frame_sel = 16'h0000;
      standby_one = 1'b1;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      repeat (BL/2) @(negedge mclk);
      check("key_on after reset", key_on, 1'b0);
      for (int b = 0; b < 64; b++) begin
         repeat (BL) @(negedge mclk);
         check("key_on stretched run", key_on, exp_key(2'h0, b));
         if (b > 0 && b <= 50 && pair_sel[2*((b-1)/2) +: 2] == pair_stretch) begin
            repeat (2) begin
               repeat (BL) @(negedge mclk);
               check("key_on stretch gap", key_on, 1'b0);
            end
         end
      end
      repeat (BL) @(negedge mclk);
      check("key_on next lead bit", key_on, 1'b1);
      // Internal oscillator; code, three silent bits, then tone through bit 50
      rst = 1'b1;
      standby_one = 1'b0;
      source_strap = 1'b1;
      pair_sel = {{22{2'h0}}, 2'h1, 2'h2, 2'h0};
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      repeat (8*BL) @(negedge mclk);
      check("key_on tone tail", key_on, 1'b1);
      @(posedge keyed_tone);
      t0 = $time;
      @(posedge keyed_tone);
      check("high tone period", ($time - t0) == 2*TH*CLK_NS, 1'b1);
      @(negedge mclk);
      rst = 1'b1;
      tone_strap_b = 1'b0;
      tone_strap_c = 1'b0;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      repeat (8*BL) @(negedge mclk);
      check("key_on tone tail low", key_on, 1'b1);
      @(posedge keyed_tone);
      t0 = $time;
      @(posedge keyed_tone);
      check("low tone period", ($time - t0) == 2*TL*CLK_NS, 1'b1);
      give_verdict();
   end
endmodule
